// File: verilog/afec_config.sv
// gain, input range and offset trim configuration of a two-channel metering front end
// assumes a synchronous register port driven by the serial interface, one access per cycle
//
// Notes on behaviour
// - Gain register bits 0 to 2 set the channel 1 amplifier gain of 1, 2, 4, 8 or 16.
// - Gain register bits 5 to 7 set the channel 2 amplifier gain from the same set.
// - Gain register bits 3 and 4 pick the channel 1 range of 0.5 V, 0.25 V or 0.125 V.
// - Each channel has its own offset trim register that cancels the offset of its samples.
// - A trim is 6-bit sign and magnitude, magnitude at most 31, lsb weight set by the LSB_SHIFT parameter.
// - The channel 1 integrator is on after power-up with no write needed.
// - The top bit of the channel 1 trim register turns the integrator off at 0 and on at 1.
`timescale 1ns/1ns
`include "afec_map.svh"

module afec_config #(
  parameter int DW = 24,
  parameter int CH1_LSB_SHIFT = 0,
  parameter int CH2_LSB_SHIFT = 0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire afec_pkg::afec_idx_t reg_idx_i,
  input wire afec_pkg::afec_reg_t reg_wdata_i,
  output afec_pkg::afec_reg_t reg_rdata_o,
  output logic reg_rvalid_o,
  output afec_pkg::afec_gain_shift_t ch1_gain_shift_o,
  output afec_pkg::afec_gain_shift_t ch2_gain_shift_o,
  output afec_pkg::afec_range_t ch1_range_shift_o,
  output logic config_reserved_o,
  output logic ch1_integrator_en_o,
  input wire logic ch1_sample_valid_i,
  input wire logic signed [DW-1:0] ch1_sample_i,
  input wire logic ch2_sample_valid_i,
  input wire logic signed [DW-1:0] ch2_sample_i,
  output logic signed [DW-1:0] ch1_trimmed_o,
  output logic ch1_trimmed_valid_o,
  output logic signed [DW-1:0] ch2_trimmed_o,
  output logic ch2_trimmed_valid_o
);

  // ----------------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------------
  function automatic afec_pkg::afec_gain_shift_t gain_shift(input logic [2:0] code);
    case (code)
      `AFEC_GAIN_X1: return `AFEC_SHIFT_X1;
      `AFEC_GAIN_X2: return `AFEC_SHIFT_X2;
      `AFEC_GAIN_X4: return `AFEC_SHIFT_X4;
      `AFEC_GAIN_X8: return `AFEC_SHIFT_X8;
      `AFEC_GAIN_X16: return `AFEC_SHIFT_X16;
      default: return `AFEC_SHIFT_X1;
    endcase
  endfunction

  function automatic logic gain_reserved(input logic [2:0] code);
    return code > `AFEC_GAIN_X16;
  endfunction

  // reserved range code falls back to the widest range
  function automatic afec_pkg::afec_range_t range_shift(input afec_pkg::afec_range_t code);
    return (code == `AFEC_RANGE_RSVD) ? `AFEC_RANGE_FULL : code;
  endfunction

  function automatic logic cfg_reserved(input afec_pkg::afec_reg_t g);
    return gain_reserved(g[`AFEC_CH1_GAIN_MSB:`AFEC_CH1_GAIN_LSB])
         | gain_reserved(g[`AFEC_CH2_GAIN_MSB:`AFEC_CH2_GAIN_LSB])
         | (g[`AFEC_RANGE_MSB:`AFEC_RANGE_LSB] == `AFEC_RANGE_RSVD);
  endfunction

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  afec_pkg::afec_reg_t gain_ff;
  afec_pkg::afec_reg_t nxt_gain;
  afec_pkg::afec_trim_t ch1_trim_ff;
  afec_pkg::afec_trim_t ch2_trim_ff;
  logic wr_gain;
  logic wr_ch1;
  logic wr_ch2;

  assign wr_gain = reg_wr_i && (reg_idx_i == `AFEC_IDX_GAIN);
  assign wr_ch1 = reg_wr_i && (reg_idx_i == `AFEC_IDX_CH1_TRIM);
  assign wr_ch2 = reg_wr_i && (reg_idx_i == `AFEC_IDX_CH2_TRIM);
  assign nxt_gain = wr_gain ? reg_wdata_i : gain_ff;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      gain_ff <= `AFEC_GAIN_RST;
    end else begin
      gain_ff <= nxt_gain;
    end
  end

  // decoded controls follow the register in the same cycle
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ch1_gain_shift_o <= gain_shift(3'(`AFEC_GAIN_RST >> `AFEC_CH1_GAIN_LSB));
      ch2_gain_shift_o <= gain_shift(3'(`AFEC_GAIN_RST >> `AFEC_CH2_GAIN_LSB));
      ch1_range_shift_o <= `AFEC_RANGE_FULL;
      config_reserved_o <= 1'b0;
    end else begin
      ch1_gain_shift_o <= gain_shift(nxt_gain[`AFEC_CH1_GAIN_MSB:`AFEC_CH1_GAIN_LSB]);
      ch2_gain_shift_o <= gain_shift(nxt_gain[`AFEC_CH2_GAIN_MSB:`AFEC_CH2_GAIN_LSB]);
      ch1_range_shift_o <= range_shift(nxt_gain[`AFEC_RANGE_MSB:`AFEC_RANGE_LSB]);
      config_reserved_o <= cfg_reserved(nxt_gain);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ch1_trim_ff <= afec_pkg::afec_trim_t'(`AFEC_CH1_TRIM_RST);
      ch1_integrator_en_o <= 1'(`AFEC_CH1_TRIM_RST >> `AFEC_INTEG_BIT);
    end else if (wr_ch1) begin
      ch1_trim_ff <= reg_wdata_i[`AFEC_TRIM_MSB:0];
      ch1_integrator_en_o <= reg_wdata_i[`AFEC_INTEG_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ch2_trim_ff <= afec_pkg::afec_trim_t'(`AFEC_CH2_TRIM_RST);
    end else if (wr_ch2) begin
      ch2_trim_ff <= reg_wdata_i[`AFEC_TRIM_MSB:0];
    end
  end

  // ----------------------------------------------------------------------
  // read path, unmapped index reads zero
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= `AFEC_RDATA_RST;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_idx_i)
          `AFEC_IDX_GAIN: reg_rdata_o <= gain_ff;
          `AFEC_IDX_CH1_TRIM: reg_rdata_o <= {ch1_integrator_en_o, 1'b0, ch1_trim_ff};
          `AFEC_IDX_CH2_TRIM: reg_rdata_o <= {2'b00, ch2_trim_ff};
          default: reg_rdata_o <= `AFEC_RDATA_RST;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // offset removal per channel
  // ----------------------------------------------------------------------
  afec_offset_trim #(
    .DW(DW),
    .LSB_SHIFT(CH1_LSB_SHIFT)
  ) u_ch1_trim (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .sample_valid_i(ch1_sample_valid_i),
    .sample_i(ch1_sample_i),
    .trim_i(ch1_trim_ff),
    .trimmed_o(ch1_trimmed_o),
    .trimmed_valid_o(ch1_trimmed_valid_o)
  );

  afec_offset_trim #(
    .DW(DW),
    .LSB_SHIFT(CH2_LSB_SHIFT)
  ) u_ch2_trim (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .sample_valid_i(ch2_sample_valid_i),
    .sample_i(ch2_sample_i),
    .trim_i(ch2_trim_ff),
    .trimmed_o(ch2_trimmed_o),
    .trimmed_valid_o(ch2_trimmed_valid_o)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  ch1_gain_field_a: assert property (
    wr_gain && (reg_wdata_i[`AFEC_CH1_GAIN_MSB:`AFEC_CH1_GAIN_LSB] == `AFEC_GAIN_X16)
    |=> ch1_gain_shift_o == `AFEC_SHIFT_X16)
    else $error("channel 1 gain 16 not selected");

  ch2_gain_field_a: assert property (
    wr_gain && (reg_wdata_i[`AFEC_CH2_GAIN_MSB:`AFEC_CH2_GAIN_LSB] == `AFEC_GAIN_X4)
    |=> ch2_gain_shift_o == `AFEC_SHIFT_X4)
    else $error("channel 2 gain 4 not selected");

  ch1_range_field_a: assert property (
    wr_gain && (reg_wdata_i[`AFEC_RANGE_MSB:`AFEC_RANGE_LSB] != `AFEC_RANGE_RSVD)
    |=> ch1_range_shift_o == $past(reg_wdata_i[`AFEC_RANGE_MSB:`AFEC_RANGE_LSB]))
    else $error("channel 1 range not taken from bits 3 and 4");

  trim_readback_a: assert property (
    wr_ch2 ##1 reg_rd_i && (reg_idx_i == `AFEC_IDX_CH2_TRIM) && !reg_wr_i
    |=> reg_rvalid_o
    && (reg_rdata_o == {2'b00, $past(reg_wdata_i[`AFEC_TRIM_MSB:0], 2)}))
    else $error("channel 2 trim did not read back");

  integ_reset_on_a: assert property (
    $past(!resetn_i) |-> ch1_integrator_en_o)
    else $error("integrator off after reset");

  integ_switch_a: assert property (
    wr_ch1 |=> ch1_integrator_en_o == $past(reg_wdata_i[`AFEC_INTEG_BIT]))
    else $error("integrator enable does not follow trim msb");

  integ_hold_a: assert property (
    !wr_ch1 |=> $stable(ch1_integrator_en_o))
    else $error("integrator enable changed without a trim write");

  reserved_gain_a: assert property (
    wr_gain && (reg_wdata_i[`AFEC_CH1_GAIN_MSB:`AFEC_CH1_GAIN_LSB] > `AFEC_GAIN_X16)
    |=> config_reserved_o && (ch1_gain_shift_o == `AFEC_SHIFT_X1))
    else $error("reserved gain code not flagged as unity");

  gain_reset_zero_a: assert property (
    $past(!resetn_i) |-> (gain_ff == `AFEC_GAIN_RST) && (ch1_gain_shift_o == `AFEC_SHIFT_X1)
    && (ch2_gain_shift_o == `AFEC_SHIFT_X1) && (ch1_range_shift_o == `AFEC_RANGE_FULL))
    else $error("gain register not zero after reset");

  integ_off_c: cover property (wr_ch1 && !reg_wdata_i[`AFEC_INTEG_BIT] ##1 !ch1_integrator_en_o);
  gain_max_c: cover property (ch1_gain_shift_o == `AFEC_SHIFT_X16
    && ch1_range_shift_o == `AFEC_RANGE_QUARTER);
  trim_read_c: cover property (reg_rd_i && reg_idx_i == `AFEC_IDX_CH1_TRIM ##1 reg_rvalid_o);

endmodule // afec_config

// File: pkg/afec_map.svh
// register indices, field positions, reset values and codes of the front-end configuration
// assumes inclusion by bare name from design files
`ifndef AFEC_MAP_SVH
`define AFEC_MAP_SVH

// ----------------------------------------------------------------------
// register indices on the serial register port
// ----------------------------------------------------------------------
`define AFEC_IDX_GAIN 2'h0
`define AFEC_IDX_CH1_TRIM 2'h1
`define AFEC_IDX_CH2_TRIM 2'h2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define AFEC_GAIN_RST 8'h00
`define AFEC_CH1_TRIM_RST 8'h80
`define AFEC_CH2_TRIM_RST 8'h00
`define AFEC_RDATA_RST 8'h00

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define AFEC_CH1_GAIN_MSB 2
`define AFEC_CH1_GAIN_LSB 0
`define AFEC_RANGE_MSB 4
`define AFEC_RANGE_LSB 3
`define AFEC_CH2_GAIN_MSB 7
`define AFEC_CH2_GAIN_LSB 5
`define AFEC_INTEG_BIT 7
`define AFEC_TRIM_MSB 5
`define AFEC_TRIM_SIGN 5
`define AFEC_TRIM_MAG_MSB 4

// ----------------------------------------------------------------------
// gain and range codes
// ----------------------------------------------------------------------
`define AFEC_GAIN_X1 3'h0
`define AFEC_GAIN_X2 3'h1
`define AFEC_GAIN_X4 3'h2
`define AFEC_GAIN_X8 3'h3
`define AFEC_GAIN_X16 3'h4
`define AFEC_SHIFT_X1 3'h0
`define AFEC_SHIFT_X2 3'h1
`define AFEC_SHIFT_X4 3'h2
`define AFEC_SHIFT_X8 3'h3
`define AFEC_SHIFT_X16 3'h4
`define AFEC_RANGE_FULL 2'h0
`define AFEC_RANGE_HALF 2'h1
`define AFEC_RANGE_QUARTER 2'h2
`define AFEC_RANGE_RSVD 2'h3

`endif

// File: pkg/afec_pkg.sv
// types shared by the front-end configuration design files
// assumes nothing of its surroundings
package afec_pkg;
  typedef logic [2:0] afec_gain_shift_t;
  typedef logic [1:0] afec_range_t;
  typedef logic [1:0] afec_idx_t;
  typedef logic [7:0] afec_reg_t;
  typedef logic [5:0] afec_trim_t;
endpackage

// File: verilog/afec_offset_trim.sv
// applies a sign-and-magnitude offset trim to one channel's sample stream
// assumes samples arrive synchronous to clk_i with a one-cycle valid strobe
`timescale 1ns/1ns
`include "afec_map.svh"

module afec_offset_trim #(
  parameter int DW = 24,
  parameter int LSB_SHIFT = 0
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic sample_valid_i,
  input wire logic signed [DW-1:0] sample_i,
  input wire afec_pkg::afec_trim_t trim_i,
  output logic signed [DW-1:0] trimmed_o,
  output logic trimmed_valid_o
);

  // ----------------------------------------------------------------------
  // arithmetic
  // ----------------------------------------------------------------------
  // sign-and-magnitude to two's complement, scaled to sample lsb
  function automatic logic signed [DW:0] trim_value(input afec_pkg::afec_trim_t t);
    logic signed [DW:0] mag;
    mag = '0;
    mag = $signed({{(DW-4){1'b0}}, t[`AFEC_TRIM_MAG_MSB:0]}) <<< LSB_SHIFT;
    return t[`AFEC_TRIM_SIGN] ? -mag : mag;
  endfunction

  function automatic logic signed [DW-1:0] trim_sat(input logic signed [DW-1:0] s,
                                                    input afec_pkg::afec_trim_t t);
    logic signed [DW:0] w;
    w = '0;
    // trim is added, so the opposite of a measured offset cancels it
    w = $signed({s[DW-1], s}) + trim_value(t);
    if (w[DW] != w[DW-1]) begin
      return w[DW] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
    end
    return w[DW-1:0];
  endfunction

  // ----------------------------------------------------------------------
  // correction stage
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      trimmed_o <= '0;
    end else if (sample_valid_i) begin
      trimmed_o <= trim_sat(sample_i, trim_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      trimmed_valid_o <= 1'b0;
    end else begin
      trimmed_valid_o <= sample_valid_i;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  offset_removed_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sample_valid_i && (sample_i == '0) && (trim_i[`AFEC_TRIM_MAG_MSB:0] == 5'h00)
    |=> trimmed_valid_o && (trimmed_o == '0))
    else $error("zero trim on zero sample did not give zero");

  trim_magnitude_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sample_valid_i && (sample_i == '0) && (trim_i[`AFEC_TRIM_SIGN] == 1'b0)
    |=> (trimmed_o == ($signed({{(DW-5){1'b0}}, $past(trim_i[`AFEC_TRIM_MAG_MSB:0])})
         <<< LSB_SHIFT)))
    else $error("positive trim not added at its magnitude");

endmodule // afec_offset_trim

// File: tb/afec_sample_src.sv
// sample source standing in for the two analog channels
// assumes the same clock as the configuration block
`timescale 1ns/1ns

module afec_sample_src (
  input wire logic clk_i,
  input wire logic send_i,
  input wire logic [23:0] s1_i,
  input wire logic [23:0] s2_i,
  output logic v1_o,
  output logic v2_o,
  output logic [23:0] smp1_o,
  output logic [23:0] smp2_o
);
  initial begin
    v1_o = 1'b0;
    v2_o = 1'b0;
    smp1_o = 24'h000000;
    smp2_o = 24'h000000;
  end
  // data between strobes is inverted each cycle, so it alternates with the last sample
  always @(posedge clk_i) begin
    v1_o <= send_i;
    v2_o <= send_i;
    smp1_o <= send_i ? s1_i : ~smp1_o;
    smp2_o <= send_i ? s2_i : ~smp2_o;
  end
endmodule // afec_sample_src

// File: tb/tb_top.sv
// self-checking bench of the front-end configuration block
// assumes the design with default parameters and the sample source model
`timescale 1ns/1ns

module tb_top;
  logic clk_i;
  logic resetn_i;
  logic wr;
  logic rd;
  logic send;
  logic rvalid;
  logic v1;
  logic v2;
  logic tv1;
  logic tv2;
  logic rsvd;
  logic integ;
  afec_pkg::afec_idx_t idx;
  afec_pkg::afec_reg_t wdata;
  afec_pkg::afec_reg_t rdata;
  afec_pkg::afec_gain_shift_t g1;
  afec_pkg::afec_gain_shift_t g2;
  afec_pkg::afec_range_t rng;
  logic [23:0] s1;
  logic [23:0] s2;
  logic signed [23:0] smp1;
  logic signed [23:0] smp2;
  logic signed [23:0] t1;
  logic signed [23:0] t2;
  int errors;
  int tests_run;

  afec_config afec_config_inst (.clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_idx_i(idx), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .ch1_gain_shift_o(g1), .ch2_gain_shift_o(g2),
    .ch1_range_shift_o(rng), .config_reserved_o(rsvd), .ch1_integrator_en_o(integ),
    .ch1_sample_valid_i(v1), .ch1_sample_i(smp1), .ch2_sample_valid_i(v2),
    .ch2_sample_i(smp2), .ch1_trimmed_o(t1), .ch1_trimmed_valid_o(tv1),
    .ch2_trimmed_o(t2), .ch2_trimmed_valid_o(tv2));

  afec_sample_src afec_sample_src_inst (.clk_i(clk_i), .send_i(send), .s1_i(s1),
    .s2_i(s2), .v1_o(v1), .v2_o(v2), .smp1_o(smp1), .smp2_o(smp2));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input afec_pkg::afec_idx_t i, input afec_pkg::afec_reg_t d);
    @(posedge clk_i);
    wr <= 1'b1;
    idx <= i;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input afec_pkg::afec_idx_t i, input afec_pkg::afec_reg_t e);
    @(posedge clk_i);
    rd <= 1'b1;
    idx <= i;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk("rvalid", 24'h000001, {23'h0, rvalid});
    chk("rdata", {16'h0, e}, {16'h0, rdata});
  endtask

  task automatic wr_rd_chk(input afec_pkg::afec_idx_t i, input afec_pkg::afec_reg_t d,
                           input afec_pkg::afec_reg_t e);
    @(posedge clk_i);
    wr <= 1'b1;
    idx <= i;
    wdata <= d;
    @(posedge clk_i);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk("rvalid", 24'h000001, {23'h0, rvalid});
    chk("rdata", {16'h0, e}, {16'h0, rdata});
  endtask

  task automatic smp_chk(input logic [23:0] a, b, ea, eb);
    @(posedge clk_i);
    send <= 1'b1;
    s1 <= a;
    s2 <= b;
    @(posedge clk_i);
    send <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("ch1_trimmed", ea, t1);
    chk("ch2_trimmed", eb, t2);
    chk("trimmed_valid", 24'h000003, {22'h0, tv1, tv2});
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    chk("gains", 24'h000000, {18'h0, g1, g2});
    chk("range", 24'h000000, {22'h0, rng});
    chk("integrator", 24'h000001, {23'h0, integ});
    rd_chk(2'h0, 8'h00);
    rd_chk(2'h1, 8'h80);
    rd_chk(2'h2, 8'h00);
  endtask

  task automatic t_gain();
    for (int c = 0; c < 5; c++) begin
      wr_reg(2'h0, {3'(c), 2'(c % 3), 3'(c)});
      chk("ch1_gain", 24'(c), {21'h0, g1});
      chk("ch2_gain", 24'(c), {21'h0, g2});
      chk("range", 24'(c % 3), {22'h0, rng});
      chk("reserved", 24'h000000, {23'h0, rsvd});
    end
    wr_reg(2'h0, 8'hA5);
    chk("reserved", 24'h000001, {23'h0, rsvd});
    chk("rsvd_gain", 24'h000000, {18'h0, g1, g2});
    wr_reg(2'h0, 8'h18);
    chk("rsvd_range", 24'h000004, {21'h0, rsvd, rng});
    wr_reg(2'h0, 8'h00);
    chk("reserved", 24'h000000, {23'h0, rsvd});
  endtask

  task automatic t_trim();
    wr_reg(2'h1, 8'h85);
    wr_reg(2'h2, 8'h25);
    smp_chk(24'h000064, 24'h000064, 24'h000069, 24'h00005F);
    wr_reg(2'h1, 8'h9F);
    wr_rd_chk(2'h2, 8'h3F, 8'h3F);
    smp_chk(24'h000000, 24'h000000, 24'h00001F, 24'hFFFFE1);
    rd_chk(2'h1, 8'h9F);
    rd_chk(2'h2, 8'h3F);
  endtask

  task automatic t_integ();
    wr_reg(2'h1, 8'h00);
    chk("integrator", 24'h000000, {23'h0, integ});
    wr_reg(2'h1, 8'h80);
    chk("integrator", 24'h000001, {23'h0, integ});
  endtask

  // calibration as software does it: integrator off, measure, trim out
  task automatic t_cal();
    wr_reg(2'h1, 8'h00);
    wr_reg(2'h2, 8'h00);
    smp_chk(24'h000000, 24'h000000, 24'h000000, 24'h000000);
    smp_chk(24'h000007, 24'hFFFFFC, 24'h000007, 24'hFFFFFC);
    wr_reg(2'h1, 8'h27);
    wr_reg(2'h2, 8'h04);
    smp_chk(24'h000007, 24'hFFFFFC, 24'h000000, 24'h000000);
    chk("integrator", 24'h000000, {23'h0, integ});
  endtask

  task automatic t_unmapped();
    wr_reg(2'h3, 8'hFF);
    rd_chk(2'h3, 8'h00);
    rd_chk(2'h0, 8'h00);
    rd_chk(2'h1, 8'h27);
    chk("integrator", 24'h000000, {23'h0, integ});
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // clock, sequence, watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    errors = 0;
    tests_run = 0;
    resetn_i = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    send = 1'b0;
    idx = 2'h0;
    wdata = 8'h00;
    s1 = 24'h000000;
    s2 = 24'h000000;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    #1;
    t_reset();
    t_gain();
    t_trim();
    t_integ();
    t_cal();
    t_unmapped();
    wrap_up();
  end

  initial begin
    #20000;
    errors++;
    wrap_up();
  end
endmodule // tb_top
